// ==== pkg/shu_pkg.sv ====
// Constants for the serially hosted UART control block: frame layout,
// command codes, field positions, reset values and receive FIFO shape.
// Assumes a 16-bit mode-0 serial host and a separate async serial engine.
package shu_pkg;

	// ==========================================================
	// Frame
	localparam int unsigned FRAME_BITS = 16;
	localparam logic [4:0] FRAME_LAST = 5'h10;
	localparam logic [4:0] CMD_READY = 5'h02;
	localparam logic [3:0] BIT_TOP = 4'hf;

	typedef enum logic [1:0] {
		SHU_RD_DATA = 2'h0,
		SHU_RD_CFG = 2'h1,
		SHU_WR_DATA = 2'h2,
		SHU_WR_CFG = 2'h3
	} shu_cmd_t;

	// ==========================================================
	// Field positions inside the 16-bit words
	localparam int unsigned POS_CMD_HI = 15;
	localparam int unsigned POS_CMD_LO = 14;
	localparam int unsigned POS_R = 15;
	localparam int unsigned POS_T = 14;
	localparam int unsigned POS_FEN = 13;
	localparam int unsigned POS_RM = 11;
	localparam int unsigned POS_PM = 10;
	localparam int unsigned POS_RAM = 9;
	localparam int unsigned POS_IR = 8;
	localparam int unsigned POS_L = 6;
	localparam int unsigned POS_PE = 5;
	localparam int unsigned POS_CTS_CFG = 4;
	localparam int unsigned POS_BAUD_HI = 3;
	localparam int unsigned POS_BAUD_LO = 0;
	localparam int unsigned POS_FE = 10;
	localparam int unsigned POS_CTS_DAT = 9;
	localparam int unsigned POS_RTS = 9;
	localparam int unsigned POS_XBIT = 8;
	localparam int unsigned POS_TOP_DATA = 7;

	// ==========================================================
	// Reset values
	localparam logic [3:0] BAUD_RST = 4'h0;
	localparam logic [7:0] WORD_RST = 8'h00;
	localparam logic [15:0] WORD16_ZERO = 16'h0000;
	localparam logic [4:0] CNT_ZERO = 5'h00;

	// ==========================================================
	// Receive FIFO: data word plus its extra bit
	localparam int unsigned FIFO_W = 9;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned FIFO_AW = 3;
	localparam logic [FIFO_AW:0] FIFO_FULL = 4'h8;
	localparam logic [FIFO_AW:0] FIFO_ONE = 4'h1;

endpackage : shu_pkg

// ==== src/shu_rx_fifo.sv ====
// Receive FIFO of the serially hosted UART: eight words, oldest first.
// Assumes push and pop are one-cycle pulses on clk; a limit of one entry
// turns it into the single receive buffer used with the FIFO bypassed.
`timescale 1ns/1ps
`default_nettype none

module shu_rx_fifo
	import shu_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic push,
	input wire logic [FIFO_W-1:0] push_word,
	input wire logic pop,
	input wire logic bypass,
	input wire logic flush,
	output logic [FIFO_W-1:0] head_word,
	output logic not_empty
);
	logic [FIFO_W-1:0] mem [FIFO_DEPTH];
	logic [FIFO_AW-1:0] rd_reg;
	logic [FIFO_AW-1:0] wr_reg;
	logic [FIFO_AW:0] cnt_reg;
	wire logic [FIFO_AW:0] limit = bypass ? FIFO_ONE : FIFO_FULL;
	wire logic do_pop = pop && (cnt_reg != '0);
	// Words that arrive while full are dropped, like an overrun, unless a pop frees a slot in the same cycle
	wire logic do_push = push && ((cnt_reg < limit) || do_pop);

	assign head_word = (cnt_reg != '0) ? mem[rd_reg] : '0;
	assign not_empty = (cnt_reg != '0);

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_reg] <= push_word;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_reg <= '0;
			wr_reg <= '0;
			cnt_reg <= '0;
		end else if (flush) begin
			rd_reg <= '0;
			wr_reg <= '0;
			cnt_reg <= '0;
		end else begin
			rd_reg <= rd_reg + FIFO_AW'(do_pop);
			wr_reg <= wr_reg + FIFO_AW'(do_push);
			cnt_reg <= cnt_reg + (FIFO_AW+1)'(do_push) - (FIFO_AW+1)'(do_pop);
		end
	end

endmodule : shu_rx_fifo

`default_nettype wire

// ==== src/shu_ctrl.sv ====
// Serially hosted UART control: 16-bit full-duplex frame slave, control
// fields, receive FIFO, flags, interrupt and handshake pins.
// Assumes host pins are asynchronous to clk (sclk period well above 4 clk)
// and the async serial engine runs on clk with pulse handshakes.
//
// Behaviour
// R1 - Every frame moves sixteen bits in and sixteen bits out together.
// R2 - First two input bits choose config write, config read, data write, data read.
// R3 - Serial input is sampled on each rising serial clock edge.
// R4 - Bit 15 appears at select fall; later bits change on falling clock edges.
// R5 - Host captures each output bit on the rising serial clock edge.
// R6 - Select rising before sixteen bits discards the frame, nothing changes.
// R7 - Frame effects are applied at the select rise ending a full frame.
// R8 - Each select fall restarts the bit counter for a new frame.
// R9 - Four-bit baud select is writable, reads back, resets to zero.
// R10 - Clear-to-send reads inverted; zero means pin high; reset leaves it alone.
// R11 - Data write carries eight bits; top bit ignored in seven-bit mode.
// R12 - Data read returns eight received bits, reset zero, top bit zero in 7-bit mode.
// R13 - Active-low FIFO bit: zero uses FIFO, one bypasses; resets zero, readable.
// R14 - Infrared timing bit selects infrared bit timing, resets zero, reads back.
// R15 - Length bit picks eight or seven bits; extra bit adds one.
// R16 - With extra enable, written extra bit is sent unchanged; else ignored.
// R17 - With extra enable, received extra bit stored with word; else reads zero.
// R18 - Three masks, reset zero, raise interrupt with extra, available, error flags.
// R19 - Available flag clears at sixteenth falling clock of data frames when empty.
// R20 - Request-to-send bit drives its active-low pin inverted; resets zero.
// R21 - Serial output is undriven while select is high; other pins except the interrupt always driven.
// R22 - Interrupt pin is active-low open drain, pulling low on unmasked condition.
// R23 - Enabled FIFO holds eight words with extra bits, delivered oldest first.
`timescale 1ns/1ps
`default_nettype none

module shu_ctrl
	import shu_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout_o,
	output logic dout_oe,
	output logic irq_n_o,
	output logic irq_n_oe,
	input wire logic cts_n,
	output logic rts_n,
	output logic [3:0] baud_divisor_select,
	output logic infrared_timing_sel,
	output logic word_len_7,
	output logic extra_bit_enable,
	output logic [7:0] transmit_word_bits,
	output logic tx_extra_bit,
	output logic tx_load,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [7:0] receive_word_bits,
	input wire logic rx_extra_bit,
	input wire logic rx_frame_error,
	input wire logic rx_activity
);
	// ==========================================================
	// Pin synchronisers
	logic [3:0] pin_s1_reg;
	logic [3:0] pin_s2_reg;
	logic cs_d_reg;
	logic sclk_d_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// Clock bit resets low, its idle level, so no false edge follows reset
			pin_s1_reg <= 4'hb;
			pin_s2_reg <= 4'hb;
		end else begin
			pin_s1_reg <= {cs_n, sclk, din, cts_n};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	wire logic cs_s = pin_s2_reg[3];
	wire logic sclk_s = pin_s2_reg[2];
	wire logic din_s = pin_s2_reg[1];
	wire logic cts_bit = ~pin_s2_reg[0]; // [R10]

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_d_reg <= 1'b1;
			sclk_d_reg <= 1'b0;
		end else begin
			cs_d_reg <= cs_s;
			sclk_d_reg <= sclk_s;
		end
	end

	wire logic cs_fall = cs_d_reg && !cs_s;
	wire logic cs_rise = !cs_d_reg && cs_s;
	wire logic in_frame = !cs_s;
	wire logic sclk_rise = in_frame && !sclk_d_reg && sclk_s;
	wire logic sclk_fall = in_frame && sclk_d_reg && !sclk_s;

	// ==========================================================
	// Control fields
	logic fifo_disable_n_reg;
	logic rx_available_irq_mask_reg;
	logic extra_bit_irq_mask_reg;
	logic activity_irq_mask_reg;
	logic infrared_reg;
	logic word_len_7_reg;
	logic extra_en_reg;
	logic [3:0] baud_reg;
	logic rts_bit_reg;
	logic fe_reg;

	// ==========================================================
	// Frame counter and shift register
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic [15:0] in_sh_reg;
	shu_cmd_t cmd_reg;
	logic [3:0] idx_reg;
	logic [FIFO_W-1:0] head_snap_reg;

	assign cnt_next = cnt_reg + 5'h01;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= CNT_ZERO;
			in_sh_reg <= WORD16_ZERO;
		end else if (cs_fall) begin
			cnt_reg <= CNT_ZERO; // [R8]
		end else if (sclk_rise && cnt_reg != FRAME_LAST) begin
			cnt_reg <= cnt_next;
			in_sh_reg <= {in_sh_reg[14:0], din_s}; // [R3] [R1]
		end
	end

	// The shift register moves on after two bits, so the command is held here
	wire logic cmd_edge = sclk_rise && !cs_fall && (cnt_next == CMD_READY);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_reg <= SHU_RD_DATA;
		end else if (cmd_edge) begin
			cmd_reg <= shu_cmd_t'({in_sh_reg[0], din_s}); // [R2]
		end
	end

	wire logic frame_full = (cnt_reg == FRAME_LAST);
	wire logic cmd_known = (cnt_reg >= CMD_READY);
	wire shu_cmd_t cmd_done = shu_cmd_t'(in_sh_reg[POS_CMD_HI:POS_CMD_LO]); // [R2]
	wire logic is_data_cmd = (cmd_reg == SHU_RD_DATA) || (cmd_reg == SHU_WR_DATA);
	// Abort leaves every field untouched
	wire logic commit = cs_rise && frame_full; // [R6] [R7]
	wire logic wr_cfg = commit && (cmd_done == SHU_WR_CFG);
	wire logic wr_data = commit && (cmd_done == SHU_WR_DATA);

	// ==========================================================
	// Receive FIFO
	logic [FIFO_W-1:0] head_word;
	logic rx_not_empty;
	// Pop as the sixteenth clock falls so the flag drops there when empty
	wire logic rx_pop = sclk_fall && (cnt_reg == FRAME_LAST) && cmd_known
		&& is_data_cmd; // [R19]
	wire logic [7:0] rx_mask = word_len_7_reg ? 8'h7f : 8'hff;
	wire logic rx_x = extra_en_reg & rx_extra_bit; // [R17]
	wire logic [FIFO_W-1:0] rx_push_word = {rx_x, receive_word_bits & rx_mask}; // [R15]

	shu_rx_fifo u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.push(rx_valid),
		.push_word(rx_push_word),
		.pop(rx_pop),
		.bypass(fifo_disable_n_reg), // [R13]
		.flush(1'b0),
		.head_word(head_word),
		.not_empty(rx_not_empty) // [R23]
	);

	// ==========================================================
	// Response word
	logic tx_pend_reg;
	wire logic t_flag = !tx_pend_reg;
	wire logic [7:0] rd_byte = head_snap_reg[7:0] & rx_mask; // [R12]
	wire logic [15:0] resp_cfg = (16'h0001 << POS_FEN) * 16'(fifo_disable_n_reg)
		| (16'h0001 << POS_RM) * 16'(rx_available_irq_mask_reg)
		| (16'h0001 << POS_PM) * 16'(extra_bit_irq_mask_reg)
		| (16'h0001 << POS_RAM) * 16'(activity_irq_mask_reg)
		| (16'h0001 << POS_IR) * 16'(infrared_reg)
		| (16'h0001 << POS_L) * 16'(word_len_7_reg)
		| (16'h0001 << POS_PE) * 16'(extra_en_reg)
		| (16'h0001 << POS_CTS_CFG) * 16'(cts_bit)
		| 16'(baud_reg); // [R9] [R13] [R14] [R18]
	wire logic [15:0] resp_data = (16'h0001 << POS_FE) * 16'(fe_reg)
		| (16'h0001 << POS_CTS_DAT) * 16'(cts_bit)
		| (16'h0001 << POS_XBIT) * 16'(head_snap_reg[FIFO_W-1])
		| 16'(rd_byte); // [R10] [R12] [R17]
	wire logic [15:0] resp_low = (cmd_reg == SHU_RD_CFG) ? resp_cfg : resp_data;
	wire logic [15:0] resp = (16'h0001 << POS_R) * 16'(rx_not_empty)
		| (16'h0001 << POS_T) * 16'(t_flag)
		| (resp_low & 16'h3fff);

	// ==========================================================
	// Serial output
	logic dout_reg;
	logic dout_oe_reg;
	wire logic [3:0] idx_next = idx_reg - 4'h1;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dout_reg <= 1'b0;
			dout_oe_reg <= 1'b0;
			idx_reg <= BIT_TOP;
			head_snap_reg <= '0;
		end else begin
			dout_oe_reg <= in_frame; // [R21]
			if (cs_fall) begin
				idx_reg <= BIT_TOP;
				head_snap_reg <= head_word;
				dout_reg <= resp[BIT_TOP]; // [R4]
			end else if (sclk_fall && idx_reg != 4'h0) begin
				idx_reg <= idx_next;
				dout_reg <= resp[idx_next]; // [R4] [R5]
			end
		end
	end

	// ==========================================================
	// Configuration commit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fifo_disable_n_reg <= 1'b0;
			rx_available_irq_mask_reg <= 1'b0;
			extra_bit_irq_mask_reg <= 1'b0;
			activity_irq_mask_reg <= 1'b0;
			infrared_reg <= 1'b0;
			word_len_7_reg <= 1'b0;
			extra_en_reg <= 1'b0;
			baud_reg <= BAUD_RST;
		end else if (wr_cfg) begin
			fifo_disable_n_reg <= in_sh_reg[POS_FEN]; // [R13]
			rx_available_irq_mask_reg <= in_sh_reg[POS_RM]; // [R18]
			extra_bit_irq_mask_reg <= in_sh_reg[POS_PM]; // [R18]
			activity_irq_mask_reg <= in_sh_reg[POS_RAM]; // [R18]
			infrared_reg <= in_sh_reg[POS_IR]; // [R14]
			word_len_7_reg <= in_sh_reg[POS_L]; // [R15]
			extra_en_reg <= in_sh_reg[POS_PE]; // [R15]
			baud_reg <= in_sh_reg[POS_BAUD_HI:POS_BAUD_LO]; // [R9]
		end
	end

	// Error flag: a new error or activity wins over a clear in the same cycle
	wire logic fe_set = rx_frame_error || rx_activity;
	wire logic fe_clr = wr_cfg || (rx_valid && !rx_frame_error);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fe_reg <= 1'b0;
		end else if (fe_set) begin
			fe_reg <= 1'b1;
		end else if (fe_clr) begin
			fe_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Transmit hand-off and handshake pin
	logic [7:0] tx_word_reg;
	logic tx_extra_reg;
	logic tx_load_reg;
	logic rts_n_reg;
	wire logic [7:0] tx_in = in_sh_reg[7:0] & rx_mask; // [R11]
	wire logic tx_go = tx_pend_reg && tx_ready && !tx_load_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_pend_reg <= 1'b0;
			tx_word_reg <= WORD_RST;
			tx_extra_reg <= 1'b0;
			tx_load_reg <= 1'b0;
			rts_bit_reg <= 1'b0;
			rts_n_reg <= 1'b1;
		end else begin
			tx_load_reg <= tx_go;
			rts_n_reg <= ~rts_bit_reg; // [R20]
			if (wr_data) begin
				tx_pend_reg <= 1'b1;
				tx_word_reg <= tx_in; // [R11]
				tx_extra_reg <= extra_en_reg & in_sh_reg[POS_XBIT]; // [R16]
				rts_bit_reg <= in_sh_reg[POS_RTS]; // [R20]
			end else if (tx_go) begin
				tx_pend_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Interrupt: drive low only, never high
	logic irq_oe_reg;
	logic irq_lvl_reg;
	wire logic irq_cond = (extra_bit_irq_mask_reg && head_word[FIFO_W-1])
		|| (rx_available_irq_mask_reg && rx_not_empty)
		|| (activity_irq_mask_reg && fe_reg); // [R18]

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_oe_reg <= 1'b0;
			irq_lvl_reg <= 1'b0;
		end else begin
			irq_oe_reg <= irq_cond; // [R22]
			irq_lvl_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Outputs
	assign dout_o = dout_reg;
	assign dout_oe = dout_oe_reg;
	assign irq_n_o = irq_lvl_reg;
	assign irq_n_oe = irq_oe_reg;
	assign rts_n = rts_n_reg;
	assign baud_divisor_select = baud_reg;
	assign infrared_timing_sel = infrared_reg;
	assign word_len_7 = word_len_7_reg;
	assign extra_bit_enable = extra_en_reg;
	assign transmit_word_bits = tx_word_reg;
	assign tx_extra_bit = tx_extra_reg;
	assign tx_load = tx_load_reg;

endmodule : shu_ctrl

`default_nettype wire

// ==== tb/shu_ctrl_asserts.sv ====
// Checker for the serially hosted UART control block ports.
// Assumes it is bound to shu_ctrl; one clk domain, reset active low.
`timescale 1ns/1ps
`default_nettype none

module shu_ctrl_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic dout_o,
	input wire logic dout_oe,
	input wire logic irq_n_o,
	input wire logic [3:0] baud_divisor_select,
	input wire logic infrared_timing_sel,
	input wire logic extra_bit_enable,
	input wire logic word_len_7,
	input wire logic [7:0] transmit_word_bits,
	input wire logic tx_extra_bit,
	input wire logic tx_load
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// ==========================================================
	// Frame steps; five samples cover the three-flop pin latency
	sequence s_idle;
		cs_n[*5];
	endsequence
	sequence s_sel;
		!cs_n[*5];
	endsequence
	sequence s_clk_high;
		(sclk && !cs_n)[*4];
	endsequence

	a_out_released: assert property (s_idle |-> !dout_oe)
		else $error("dout driven while deselected");
	a_out_driven: assert property (s_sel |-> dout_oe)
		else $error("dout not driven while selected");
	a_out_held: assert property (s_clk_high |-> $stable(dout_o))
		else $error("dout moved while sclk high");
	a_fields_held: assert property (s_sel |-> $stable({baud_divisor_select,
		infrared_timing_sel, extra_bit_enable, word_len_7}))
		else $error("config changed inside a frame");
	a_irq_open_drain: assert property (!irq_n_o)
		else $error("irq line driven high");
	a_tx_seven_bit: assert property (tx_load && word_len_7 |-> !transmit_word_bits[7])
		else $error("top tx bit sent in 7-bit mode");
	a_tx_extra_off: assert property (tx_load && !extra_bit_enable |-> !tx_extra_bit)
		else $error("extra bit sent while disabled");
	a_tx_pulse_once: assert property (tx_load |=> !tx_load)
		else $error("tx_load longer than one cycle");
	a_tx_after_commit: assert property (tx_load |-> cs_n && $past(cs_n, 3))
		else $error("tx_load outside frame end");
endmodule : shu_ctrl_asserts

`default_nettype wire

// ==== tb/shu_host_model.sv ====
// Host model: mode-0 serial master driving select, clock and data.
// Assumes calls from the bench at the falling clk edge, one at a time.
`timescale 1ns/1ps
`default_nettype none

module shu_host_model (
	input wire logic clk,
	input wire logic miso,
	output logic cs_n,
	output logic sclk,
	output logic mosi
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b1;
	end

	// ==========================================================
	// One frame of n bits; n below 16 gives an aborted frame
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
		r = 16'h0000;
		cs_n = 1'b0;
		mosi = w[15];
		repeat (4) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			sclk = 1'b1;
			r[15 - i] = miso;
			repeat (4) @(negedge clk);
			sclk = 1'b0;
			mosi = (i < 15) ? w[14 - i] : ~mosi;
			repeat (4) @(negedge clk);
		end
		// Released data line shows no stale value
		cs_n = 1'b1;
		mosi = ~mosi;
		repeat (8) @(negedge clk);
	endtask : xfer
endmodule : shu_host_model

`default_nettype wire

// ==== tb/tb.sv ====
// Bench for shu_ctrl: host frames through the host model, engine side
// driven directly at the falling clk edge.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import shu_pkg::*;
	logic clk, rst_b, cts_n, tx_ready, rx_valid, rx_xb, rx_fe, rx_act;
	logic [7:0] rx_word;
	logic [15:0] r, tx_seen;
	wire logic cs_n, sclk, din, dout_o, dout_oe, irq_n_o, irq_n_oe, rts_n;
	wire logic ir, l7, pe, tx_xb, tx_load, miso, irq_w;
	wire logic [3:0] baud;
	wire logic [7:0] tx_word;
	int error_cnt = 0;
	int checks = 0;
	int tx_cnt = 0;

	assign miso = dout_oe ? dout_o : 1'bz;
	// Pull-up on the shared interrupt line
	assign irq_w = irq_n_oe ? irq_n_o : 1'b1;

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	shu_ctrl DUT (.clk(clk), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout_o(dout_o), .dout_oe(dout_oe), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
		.cts_n(cts_n), .rts_n(rts_n), .baud_divisor_select(baud),
		.infrared_timing_sel(ir), .word_len_7(l7), .extra_bit_enable(pe),
		.transmit_word_bits(tx_word), .tx_extra_bit(tx_xb), .tx_load(tx_load),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .receive_word_bits(rx_word),
		.rx_extra_bit(rx_xb), .rx_frame_error(rx_fe), .rx_activity(rx_act));

	shu_host_model u_host (.clk(clk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(din));

	always @(negedge clk) begin
		if (tx_load === 1'b1) begin
			tx_seen <= {7'h00, tx_xb, tx_word};
			tx_cnt <= tx_cnt + 1;
		end
	end

	// ==========================================================
	// Tasks
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic push(input logic [7:0] w, input logic xb);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_word = w;
		rx_xb = xb;
		@(negedge clk);
		rx_valid = 1'b0;
	endtask : push

	task automatic print_verdict();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict

	// ==========================================================
	// Scenarios
	initial begin
		rst_b = 1'b0;
		cts_n = 1'b0;
		tx_ready = 1'b1;
		rx_valid = 1'b0;
		rx_word = 8'h00;
		rx_xb = 1'b0;
		rx_fe = 1'b0;
		rx_act = 1'b0;
		repeat (3) @(negedge clk);
		chk("rst_pins", {rts_n, irq_w, dout_oe, ir, l7, pe, baud}, 16'h0300);
		rst_b = 1'b1;
		repeat (6) @(negedge clk);
		u_host.xfer(16'h4000, 16, r);
		chk("cfg_reset", r, 16'h4010);
		u_host.xfer(16'hc92a, 16, r);
		chk("cfg_fields", {ir, l7, pe, baud}, 16'h005a);
		cts_n = 1'b1;
		u_host.xfer(16'hc000, 15, r);
		chk("abort_fields", {ir, l7, pe, baud}, 16'h005a);
		u_host.xfer(16'h4000, 16, r);
		chk("cfg_back", r, 16'h492a);
		// Nine words into an eight-deep FIFO: the last one is dropped
		for (int i = 0; i < 9; i++) push(8'h30 + i[7:0], i[0]);
		@(negedge clk);
		chk("irq_avail", irq_w, 16'h0000);
		for (int i = 0; i < 9; i++) begin
			u_host.xfer(16'h0000, 16, r);
			if (i < 8) chk("rd_fifo", r, {8'hc0 | i[7:0] & 8'h01, 8'h30 + i[7:0]});
			else chk("rd_empty", r[15], 16'h0000);
		end
		chk("irq_clear", irq_w, 16'h0001);
		u_host.xfer(16'hc96a, 16, r);
		push(8'hff, 1'b1);
		u_host.xfer(16'h83ff, 16, r);
		chk("rd_7bit", r, 16'hc17f);
		chk("tx_7bit", tx_seen, 16'h017f);
		chk("rts_on", rts_n, 16'h0000);
		u_host.xfer(16'hc94a, 16, r);
		push(8'h55, 1'b1);
		u_host.xfer(16'h81aa, 16, r);
		chk("rd_no_extra", r, 16'hc055);
		chk("tx_no_extra", tx_seen, 16'h002a);
		chk("tx_count", tx_cnt[15:0], 16'h0002);
		chk("rts_off", rts_n, 16'h0001);
		u_host.xfer(16'he620, 16, r);
		chk("irq_idle", irq_w, 16'h0001);
		u_host.xfer(16'h4000, 16, r);
		chk("cfg_bypass", r, 16'h6620);
		// Single buffer: the second word finds it full and is dropped
		push(8'h12, 1'b1);
		push(8'h34, 1'b0);
		@(negedge clk);
		chk("irq_extra", irq_w, 16'h0000);
		rx_act = 1'b1;
		@(negedge clk);
		rx_act = 1'b0;
		u_host.xfer(16'h0000, 16, r);
		chk("rd_bypass", r, 16'hc512);
		chk("irq_error", irq_w, 16'h0000);
		u_host.xfer(16'h0000, 16, r);
		chk("rd_dropped", r, 16'h4400);
		u_host.xfer(16'hc000, 16, r);
		chk("irq_cleared", irq_w, 16'h0001);
		print_verdict();
	end
endmodule : tb

bind shu_ctrl shu_ctrl_asserts u_chk (.clk(clk), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk),
	.dout_o(dout_o), .dout_oe(dout_oe), .irq_n_o(irq_n_o),
	.baud_divisor_select(baud_divisor_select), .infrared_timing_sel(infrared_timing_sel),
	.extra_bit_enable(extra_bit_enable), .word_len_7(word_len_7),
	.transmit_word_bits(transmit_word_bits), .tx_extra_bit(tx_extra_bit), .tx_load(tx_load));

`default_nettype wire
